//--- core/isw_ctrl.sv
// Purpose: Link controller that writes or reads the switch channel byte
// Assumes: Software issues one transfer at a time over AXI4-Lite
// Notes:   One data byte per transfer; a read byte is always not-acknowledged
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module isw_ctrl (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link
  isw_link_if.ctrl         link
);
  typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} isw_mst_e;
  isw_mst_e   state_reg;     // Link sequencer state
  logic [3:0] aw_addr_reg;   // Captured write address
  logic       aw_have_reg;   // Write address held
  logic [31:0] w_data_reg;   // Captured write data
  logic [3:0] w_strb_reg;    // Captured byte enables
  logic       w_have_reg;    // Write data held
  logic       wr_fire;       // Register write happens now
  logic [7:0] wbyte_reg;     // Byte to send to the switch
  logic       rd_reg;        // Transfer direction, 1 = read
  logic [2:0] tgt_reg;       // Switch pin address
  logic       go_reg;        // Transfer requested, waits for idle bus
  logic       busy_reg;      // Transfer under way
  logic       nack_reg;      // Last transfer was refused
  logic [7:0] rdata_reg;     // Byte read back
  logic [3:0] cnt_reg;       // Phase in bit slot
  logic [2:0] bit_reg;       // Bit index in byte
  logic       byte_sel_reg;  // 0 = address byte, 1 = data byte
  logic [7:0] shift_reg;     // Outgoing bits
  logic [7:0] rx_reg;        // Incoming bits
  logic       got_ack_reg;   // Acknowledge seen in the slot
  logic       zero_reg;      // Constant low drive value
  logic [2:0] s1_reg, s2_reg, s3_reg; // Line synchronisers
  logic [1:0] line_f_reg;    // Filtered sda (0) and scl (1)

  assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;

  // Line synchronisers: take the change once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_reg <= 3'h7;
      s2_reg <= 3'h7;
      s3_reg <= 3'h7;
    end else begin
      s1_reg <= {1'b1, link.scl, link.sda};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      // Filter stage per line
      always_ff @(posedge clk_sys) begin
        if (srst) line_f_reg[g] <= 1'b1;
        else if (s2_reg[g] == s3_reg[g]) line_f_reg[g] <= s3_reg[g];
      end
    end
  endgenerate

  // Write address and data channels, taken in either order
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= isw_pkg::RESP_OKAY;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_have_reg & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_reg & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end else if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        // Status register and holes refuse writes
        s_axi_bresp  <= (aw_addr_reg == isw_pkg::OFS_CMD || aw_addr_reg == isw_pkg::OFS_TARGET)
                        ? isw_pkg::RESP_OKAY : isw_pkg::RESP_SLVERR;
      end
    end
  end

  // Software registers; settings are frozen while a transfer runs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wbyte_reg <= 8'h00;
      rd_reg    <= 1'b0;
      tgt_reg   <= 3'h0;
      go_reg    <= 1'b0;
    end else if (wr_fire && !busy_reg && !go_reg) begin
      if (aw_addr_reg == isw_pkg::OFS_CMD) begin
        if (w_strb_reg[0]) wbyte_reg <= w_data_reg[7:0];
        if (w_strb_reg[1]) begin
          rd_reg <= w_data_reg[isw_pkg::CMD_READ_BIT];
          go_reg <= w_data_reg[isw_pkg::CMD_GO_BIT];
        end
      end else if (aw_addr_reg == isw_pkg::OFS_TARGET && w_strb_reg[0]) begin
        tgt_reg <= w_data_reg[2:0];
      end
    end else if (state_reg == M_IDLE && go_reg && line_f_reg == 2'h3) begin
      go_reg <= 1'b0; // Transfer begins only on an idle bus
    end
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= isw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= isw_pkg::RESP_OKAY;
      case (s_axi_araddr)
        isw_pkg::OFS_CMD:    s_axi_rdata <= {23'h0, rd_reg, wbyte_reg};
        isw_pkg::OFS_TARGET: s_axi_rdata <= {29'h0, tgt_reg};
        isw_pkg::OFS_STATUS: s_axi_rdata <= {16'h0, rdata_reg, 6'h0, nack_reg, busy_reg | go_reg};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= isw_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

  // Link sequencer: one bit slot is LINK_DIV clocks, clock low in the first half
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg     <= M_IDLE;
      cnt_reg       <= 4'h0;
      bit_reg       <= 3'h0;
      byte_sel_reg  <= 1'b0;
      shift_reg     <= 8'h00;
      rx_reg        <= 8'h00;
      got_ack_reg   <= 1'b0;
      busy_reg      <= 1'b0;
      nack_reg      <= 1'b0;
      rdata_reg     <= 8'h00;
      link.scl_oe   <= 1'b0;
      link.m_sda_oe <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == isw_pkg::PH_LAST) ? 4'h0 : cnt_reg + 4'h1;
      case (state_reg)
        M_IDLE: begin
          cnt_reg       <= 4'h0;
          link.scl_oe   <= 1'b0; // Both lines rest high
          link.m_sda_oe <= 1'b0;
          if (go_reg && line_f_reg == 2'h3) begin
            state_reg <= M_START;
            busy_reg  <= 1'b1;
            nack_reg  <= 1'b0;
            shift_reg <= {isw_pkg::DEV_ADDR_HI, tgt_reg, rd_reg};
          end
        end
        M_START: begin
          // Data falls while clock is high
          if (cnt_reg == isw_pkg::PH_START) link.m_sda_oe <= 1'b1;
          if (cnt_reg == isw_pkg::PH_LAST) begin
            state_reg    <= M_BIT;
            bit_reg      <= 3'h0;
            byte_sel_reg <= 1'b0;
          end
        end
        M_BIT, M_ACK: begin
          if (cnt_reg == 4'h0) link.scl_oe <= 1'b1;
          // Data changes only while clock is low
          if (cnt_reg == isw_pkg::PH_DATA) begin
            // Released in the acknowledge slot and for read data
            link.m_sda_oe <= (state_reg == M_BIT) && !(byte_sel_reg && rd_reg) && !shift_reg[7];
          end
          if (cnt_reg == isw_pkg::PH_RISE) link.scl_oe <= 1'b0;
          if (cnt_reg == isw_pkg::PH_SAMPLE) begin
            // Acknowledge slot must not shift into the read byte
            if (state_reg == M_BIT) rx_reg <= {rx_reg[6:0], line_f_reg[0]};
            got_ack_reg <= ~line_f_reg[0]; // Low line at the PH_SAMPLE point of the high phase
          end
          if (cnt_reg == isw_pkg::PH_LAST) begin
            if (state_reg == M_BIT) begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_reg   <= bit_reg + 3'h1;
              if (bit_reg == isw_pkg::BIT_LAST) state_reg <= M_ACK;
            end else if (!byte_sel_reg && got_ack_reg) begin
              state_reg    <= M_BIT; // Data follows an acknowledged address
              byte_sel_reg <= 1'b1;
              bit_reg      <= 3'h0;
              shift_reg    <= wbyte_reg;
            end else begin
              state_reg <= M_STOP;
              nack_reg  <= !got_ack_reg && !(byte_sel_reg && rd_reg);
              // Single read byte is the last, so no acknowledge
              if (byte_sel_reg && rd_reg) rdata_reg <= rx_reg;
            end
          end
        end
        M_STOP: begin
          if (cnt_reg == 4'h0) link.scl_oe <= 1'b1;
          if (cnt_reg == isw_pkg::PH_DATA) link.m_sda_oe <= 1'b1;
          if (cnt_reg == isw_pkg::PH_RISE) link.scl_oe <= 1'b0;
          // Data rises while clock is high
          if (cnt_reg == isw_pkg::PH_STOP) link.m_sda_oe <= 1'b0;
          if (cnt_reg == isw_pkg::PH_LAST) begin
            state_reg <= M_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end

  // Low drive value for both open-drain outputs
  always_ff @(posedge clk_sys) begin
    zero_reg <= 1'b0;
  end
  assign link.scl_o   = zero_reg;
  assign link.m_sda_o = zero_reg;
endmodule : isw_ctrl

//--- core/isw_pkg.sv
// Purpose: Shared constants for the two-wire channel-switch link and its controller
// Assumes: clk_sys at 10 MHz on both ends
// Notes:   Byte offsets on the register bus are word aligned
package isw_pkg;
  // System clock and link bit period
  localparam int CLK_PERIOD_NS  = 100;
  localparam int LINK_PERIOD_NS = 1600;
  localparam int LINK_DIV       = LINK_PERIOD_NS / CLK_PERIOD_NS;
  // Phases inside one bit slot of the controller
  localparam logic [3:0] PH_LAST   = 4'(LINK_DIV - 1);
  localparam logic [3:0] PH_DATA   = 4'h2;
  localparam logic [3:0] PH_RISE   = 4'(LINK_DIV / 2);
  localparam logic [3:0] PH_START  = 4'h4;
  localparam logic [3:0] PH_STOP   = 4'hc;
  localparam logic [3:0] PH_SAMPLE = 4'he;
  // Bits per byte and last bit index
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  // Fixed upper address bits of the switch (arbitrary value)
  localparam logic [3:0] DEV_ADDR_HI = 4'h5;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] CHAN_RST = 4'h0;
  // Controller registers: byte offsets
  localparam logic [3:0] OFS_CMD    = 4'h0;
  localparam logic [3:0] OFS_TARGET = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // CMD fields
  localparam int CMD_READ_BIT = 8;
  localparam int CMD_GO_BIT   = 9;
  // STATUS fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RD_LSB   = 8;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : isw_pkg

//--- core/isw_link_if.sv
// Purpose: Two-wire link between controller and switch, with pull-ups
// Assumes: Both lines are open drain; a released line reads high
// Notes:   Only the controller drives the clock line
`timescale 1ns/10ps
interface isw_link_if;
  logic scl_o;     // Controller clock drive value
  logic scl_oe;    // Controller clock drive enable
  logic m_sda_o;   // Controller data drive value
  logic m_sda_oe;  // Controller data drive enable
  logic d_sda_o;   // Switch data drive value
  logic d_sda_oe;  // Switch data drive enable
  logic scl;       // Resolved clock line
  logic sda;       // Resolved data line
  // Wired-and with pull-up
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(m_sda_oe & ~m_sda_o) & ~(d_sda_oe & ~d_sda_o);
  modport ctrl (output scl_o, scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport dev  (output d_sda_o, d_sda_oe, input scl, sda);
endinterface : isw_link_if

//--- core/isw_dev.sv
// Purpose: Two-wire slave and power-on start-up of a four-channel bus switch
// Assumes: Link lines are asynchronous to clk_sys and filtered here
// Notes:   Supply state arrives as two level inputs from an analog monitor
`timescale 1ns/10ps
// Functional notes
// - Hold everything in reset until supply good
// - Release clears register and protocol state
// - Re-arm start-up reset only below 0.2 V
// - Master starts transfers only on idle bus
// - One bit per clock; data stable high
// - Idle bus has both lines high
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Unlimited data bytes between START and STOP
// - Eight bits then one acknowledge slot
// - Transmitter releases data in acknowledge slot
// - Addressed receiver acknowledges every byte
// - Master acknowledges read bytes except last
// - Acknowledge holds data low through high
// - Master ends read by withholding acknowledge
// - No acknowledge: transmitter releases data line
// - Write loads, read returns channel byte
// - Address bit zero: one read, zero write
// - Keep only last byte of a write
// - Low four bits enable channels, any mix
// - New selection applies at next STOP
module isw_dev (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Supply monitor
  input  wire logic       supply_ok,      // Supply at startup_release_threshold or above
  input  wire logic       supply_low,     // Supply below 0.2 V
  // Configuration
  input  wire logic [2:0] addr_pins,      // Pin-configured address
  // Switch control
  output logic [3:0]      chan_en,        // Enable per downstream channel
  // Link
  isw_link_if.dev         link
);
  typedef enum {D_IDLE, D_ADDR, D_ADDR_ACK, D_WR, D_WR_ACK, D_RD, D_RD_ACK, D_IGNORE} isw_dev_e;
  isw_dev_e   state_reg;    // Protocol state
  logic [3:0] s1_reg;       // First sync stage: scl, sda, ok, low
  logic [3:0] s2_reg;       // Second sync stage
  logic [3:0] s3_reg;       // Third sync stage
  logic [3:0] f_reg;        // Filtered inputs
  logic [1:0] prev_reg;     // Previous filtered scl and sda
  logic       por_hold_reg; // Start-up reset holding
  logic       rst_all;      // Any reset of the protocol logic
  logic       scl_f;        // Filtered clock line
  logic       sda_f;        // Filtered data line
  logic       scl_rise;     // Clock went high
  logic       scl_fall;     // Clock went low
  logic       start_ev;     // START seen
  logic       stop_ev;      // STOP seen
  logic [3:0] bit_cnt_reg;  // Bits shifted in this byte
  logic [7:0] rx_reg;       // Incoming bits
  logic [7:0] tx_reg;       // Outgoing bits
  logic [7:0] ctrl_reg;     // Channel-select register
  logic       acked_reg;    // Master acknowledged the read byte
  logic       wr_done;      // Data byte complete in write mode
  logic       zero_reg;     // Constant low drive value
  logic [3:0] raw_in;       // Asynchronous inputs gathered

  assign raw_in   = {supply_low, supply_ok, link.sda, link.scl};
  assign scl_f    = f_reg[0];
  assign sda_f    = f_reg[1];
  assign rst_all  = srst | por_hold_reg;
  assign scl_rise = scl_f & ~prev_reg[0];
  assign scl_fall = ~scl_f & prev_reg[0];
  assign start_ev = scl_f & prev_reg[0] & ~sda_f & prev_reg[1];
  assign stop_ev  = scl_f & prev_reg[0] & sda_f & ~prev_reg[1];
  assign wr_done  = (state_reg == D_WR) && scl_fall && bit_cnt_reg == isw_pkg::BYTE_BITS;

  // Three-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_reg <= 4'h3;
      s2_reg <= 4'h3;
      s3_reg <= 4'h3;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_filt
      // A change counts once stages two and three agree
      always_ff @(posedge clk_sys) begin
        if (srst) f_reg[g] <= (g < 2);
        else if (s2_reg[g] == s3_reg[g]) f_reg[g] <= s3_reg[g];
      end
    end
  endgenerate

  // Edge history of the filtered lines; idle level is high
  always_ff @(posedge clk_sys) begin
    if (rst_all) prev_reg <= 2'h3;
    else prev_reg <= {sda_f, scl_f};
  end

  // Start-up reset; a brown-out above 0.2 V does not re-arm it
  always_ff @(posedge clk_sys) begin
    if (srst) por_hold_reg <= 1'b1;
    else if (f_reg[3]) por_hold_reg <= 1'b1;
    else if (f_reg[2]) por_hold_reg <= 1'b0;
  end

  // Protocol state machine and data-line drive
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      state_reg     <= D_IDLE;
      bit_cnt_reg   <= 4'h0;
      rx_reg        <= 8'h00;
      tx_reg        <= 8'h00;
      acked_reg     <= 1'b0;
      link.d_sda_oe <= 1'b0;
    end else if (stop_ev) begin
      state_reg     <= D_IDLE;
      link.d_sda_oe <= 1'b0;
    end else if (start_ev) begin
      // Repeated START also restarts address capture
      state_reg     <= D_ADDR;
      bit_cnt_reg   <= 4'h0;
      link.d_sda_oe <= 1'b0;
    end else begin
      case (state_reg)
        D_ADDR, D_WR: begin
          if (scl_rise) begin
            rx_reg      <= {rx_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == isw_pkg::BYTE_BITS) begin
            if (state_reg == D_WR) begin
              state_reg     <= D_WR_ACK;
              link.d_sda_oe <= 1'b1;
            end else if (rx_reg[7:1] == {isw_pkg::DEV_ADDR_HI, addr_pins}) begin
              state_reg     <= D_ADDR_ACK;
              link.d_sda_oe <= 1'b1;
              acked_reg     <= rx_reg[0];  // Holds direction here
            end else begin
              state_reg <= D_IGNORE;
            end
          end
        end
        D_ADDR_ACK, D_WR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == D_ADDR_ACK && acked_reg) begin
              // First read bit out as the acknowledge ends
              state_reg     <= D_RD;
              link.d_sda_oe <= ~ctrl_reg[7];
              tx_reg        <= {ctrl_reg[6:0], 1'b0};
              bit_cnt_reg   <= 4'h1;
            end else begin
              state_reg     <= D_WR;  // Any count of bytes follows
              link.d_sda_oe <= 1'b0;
            end
          end
        end
        D_RD: begin
          if (scl_fall) begin
            if (bit_cnt_reg == isw_pkg::BYTE_BITS) begin
              state_reg     <= D_RD_ACK;
              link.d_sda_oe <= 1'b0;
            end else begin
              link.d_sda_oe <= ~tx_reg[7];
              tx_reg        <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg   <= bit_cnt_reg + 4'h1;
            end
          end
        end
        D_RD_ACK: begin
          if (scl_rise) begin
            acked_reg <= ~sda_f;
          end else if (scl_fall) begin
            if (acked_reg) begin
              // Acknowledged: send the register again
              state_reg     <= D_RD;
              link.d_sda_oe <= ~ctrl_reg[7];
              tx_reg        <= {ctrl_reg[6:0], 1'b0};
              bit_cnt_reg   <= 4'h1;
            end else begin
              state_reg     <= D_IGNORE;
              link.d_sda_oe <= 1'b0;
            end
          end
        end
        D_IGNORE: link.d_sda_oe <= 1'b0;  // Wait for STOP or START
        D_IDLE:   link.d_sda_oe <= 1'b0;
        default:  state_reg <= D_IDLE;
      endcase
    end
  end

  // Channel-select register; each new byte overwrites the last
  always_ff @(posedge clk_sys) begin
    if (rst_all) ctrl_reg <= isw_pkg::CTRL_RST;
    else if (wr_done) ctrl_reg <= rx_reg;
  end

  // Switch enables follow the register only at STOP, so lines are idle high
  always_ff @(posedge clk_sys) begin
    if (rst_all) chan_en <= isw_pkg::CHAN_RST;
    else if (stop_ev) chan_en <= ctrl_reg[3:0];
  end

  // Low drive value for the open-drain data output
  always_ff @(posedge clk_sys) begin
    zero_reg <= 1'b0;
  end
  assign link.d_sda_o = zero_reg;
endmodule : isw_dev

//--- testbench/isw_link_chk.sv
// Purpose: Protocol checks on the two-wire link between controller and switch
// Assumes: Bit slots have scl rising once per bit; the start slot keeps scl high
// Notes:   Rise counter restarts at each START
`timescale 1ns/10ps
module isw_link_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Link lines and drive enables
  input wire logic scl_oe,
  input wire logic m_sda_oe,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic       scl_q;  // Clock line one cycle back
  logic       sda_q;  // Data line one cycle back
  logic [4:0] cnt;    // Clock rises since START
  logic       rw_q;   // Direction bit of this frame
  logic       ack_q;  // Address was acknowledged
  wire rise    = scl & ~scl_q;
  wire start_c = scl & scl_q & sda_q & ~sda;
  wire stop_c  = scl & scl_q & ~sda_q & sda;
  // Line history; idle-high reset avoids a false edge after reset
  always_ff @(posedge clk_sys) begin
    scl_q <= srst ? 1'b1 : scl;
    sda_q <= srst ? 1'b1 : sda;
  end
  // Frame position and captured address outcome
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt   <= 5'h00;
      rw_q  <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      if (start_c) cnt <= 5'h00;
      else if (rise && cnt != 5'h1f) cnt <= cnt + 5'h01;
      if (rise && cnt == 5'h07) rw_q <= sda;
      if (rise && cnt == 5'h08) ack_q <= ~sda;
    end
  end
  a_dev_data_hold: assert property ($changed(d_sda_oe) |-> !scl) else $error("switch moved data while clock high");
  a_ctrl_data_hold: assert property ($changed(m_sda_oe) && !scl_oe |-> start_c || stop_c) else $error("controller moved data while clock high");
  a_start_by_ctrl: assert property (start_c |-> m_sda_oe && !d_sda_oe) else $error("start not made by controller");
  a_stop_by_ctrl: assert property (stop_c |-> $past(m_sda_oe) && !d_sda_oe) else $error("stop not made by controller");
  a_idle_after_stop: assert property (stop_c |=> (scl && sda) [*3]) else $error("lines not idle high after stop");
  a_frame_length: assert property (stop_c |-> cnt == 5'h13 || (cnt == 5'h0a && !ack_q)) else $error("bad clock count in frame");
  a_ack_slot_free: assert property (rise && (cnt == 5'h08 || cnt == 5'h11) |-> !m_sda_oe) else $error("controller drove ack slot");
  a_dev_byte_ack: assert property (rise && cnt == 5'h11 && !rw_q && ack_q |-> d_sda_oe) else $error("switch missed data ack");
  a_rd_nack_free: assert property (cnt == 5'h12 && rw_q |-> !d_sda_oe) else $error("switch held data after nack");
  a_wrong_addr_quiet: assert property (cnt >= 5'h09 && !ack_q |-> !d_sda_oe) else $error("unaddressed switch drove data");
  c_write: cover property (stop_c && cnt == 5'h13 && !rw_q);
  c_read: cover property (stop_c && cnt == 5'h13 && rw_q);
  c_nack: cover property (stop_c && cnt == 5'h0a);
endmodule : isw_link_chk

//--- testbench/i2c_switch_control_slave_por_tb.sv
// Purpose: Controller and switch joined on one link, driven over AXI4-Lite
// Assumes: Controller sends the address byte and at most one data byte per frame
// Notes:   Supply inputs are stepped to exercise start-up reset
`timescale 1ns/10ps
module i2c_switch_control_slave_por_tb;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        supply_ok = 1'b0;
  logic        supply_low = 1'b0;
  logic [2:0]  addr_pins = 3'h3;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rv;
  logic [3:0]  chan_en, keep;
  logic [7:0]  vals [3] = '{8'h05, 8'h0a, 8'hf3};
  int          n_fail = 0;
  int          total_checks = 0;
  isw_link_if link ();
  isw_ctrl isw_ctrl_i (.clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  isw_dev isw_dev_i (.clk_sys(clk_sys), .srst(srst), .supply_ok(supply_ok), .supply_low(supply_low),
    .addr_pins(addr_pins), .chan_en(chan_en), .link(link));
  isw_link_chk isw_link_chk_i (.clk_sys(clk_sys), .srst(srst), .scl_oe(link.scl_oe),
    .m_sda_oe(link.m_sda_oe), .d_sda_oe(link.d_sda_oe), .scl(link.scl), .sda(link.sda));
  // 10 MHz system clock
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Write: each channel released once taken, then wait for the response
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask : rd
  // One link frame; channels must keep their old value 200 cycles in, before the STOP of a full frame
  task automatic xfer(input logic [2:0] t, input logic [31:0] c, input logic [3:0] old);
    wr(isw_pkg::OFS_TARGET, 32'(t), rs);
    wr(isw_pkg::OFS_CMD, c, rs);
    repeat (200) @(posedge clk_sys);
    chk(32'(chan_en), 32'(old));
    do rd(isw_pkg::OFS_STATUS, rv, rs); while (rv[isw_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask : xfer
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0; supply_ok <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk(32'(chan_en), 32'h0);
    keep = 4'h0;
    for (int i = 0; i < 3; i++) begin
      xfer(3'h3, {22'h0, 2'b10, vals[i]}, keep);
      chk(32'(rv[isw_pkg::STAT_NACK_BIT]), 32'h0);
      chk(32'(chan_en), 32'(vals[i][3:0]));
      keep = vals[i][3:0];
      xfer(3'h3, {22'h0, 2'b11, 8'h00}, keep);
      chk(32'(rv[15:8]), 32'(vals[i]));
    end
    xfer(3'h6, {22'h0, 2'b10, 8'h0c}, keep);
    chk(32'(rv[isw_pkg::STAT_NACK_BIT]), 32'h1);
    chk(32'(chan_en), 32'h3);
    wr(isw_pkg::OFS_STATUS, 32'h0, rs);
    chk(32'(rs), 32'(isw_pkg::RESP_SLVERR));
    rd(4'hc, rv, rs);
    chk({rv[29:0], rs}, 32'(isw_pkg::RESP_SLVERR));
    supply_ok <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk(32'(chan_en), 32'h3);
    supply_low <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk(32'(chan_en), 32'h0);
    supply_low <= 1'b0; supply_ok <= 1'b1;
    repeat (20) @(posedge clk_sys);
    xfer(3'h3, {22'h0, 2'b10, 8'h09}, 4'h0);
    chk(32'(chan_en), 32'h9);
    wrap_up();
  end
endmodule : i2c_switch_control_slave_por_tb
